// file: cluster_counter_irq_pkg.sv
// package: encodings, field layout and access outcome types for the counter irq enable bank
package cluster_counter_irq_pkg;

  localparam int NUM_COUNTERS = 6;
  localparam int REG_WIDTH = 64;

  // system register encodings {op0,op1,crn,crm,op2}
  localparam logic [15:0] ENC_IRQ_ENABLE_SET = 16'hC7AE;
  localparam logic [15:0] ENC_IRQ_ENABLE_CLEAR = 16'hC7AF;

  localparam logic [5:0] SYNDROME_SYSREG_TRAP = 6'h18;

  localparam logic [NUM_COUNTERS-1:0] ENABLE_RESET_VALUE = 6'h00;
  localparam logic [NUM_COUNTERS-1:0] OVF_RESET_VALUE = 6'h00;

  typedef enum logic [1:0] {
    EL_USER,
    EL_KERNEL,
    EL_HYP,
    EL_MONITOR
  } exc_level_t;

  typedef enum logic [1:0] {
    ACC_OK,
    ACC_UNDEF,
    ACC_TRAP_HYP,
    ACC_TRAP_MON
  } access_result_t;

  // request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] encoding;
    logic [REG_WIDTH-1:0] wdata;
    exc_level_t level;
  } sysreg_req_t;

  // controls that gate the access checks
  typedef struct packed {
    logic hyp_enabled;
    logic impdef_reg_trap_control;
    logic hyp_cluster_counter_access_enable;
    logic mon_cluster_counter_access_enable;
    logic debug_halted;
    logic secure_debug_disable;
    logic mon_trap_priority;
  } access_ctrl_t;

  typedef struct packed {
    logic valid;
    access_result_t result;
    logic [5:0] syndrome;
    logic [REG_WIDTH-1:0] rdata;
  } sysreg_resp_t;

endpackage

// file: access_checker.sv
// access checker: decides the outcome of a system register access
`timescale 1ns/10ps
`default_nettype none
module access_checker
  import cluster_counter_irq_pkg::*;
(
  input wire logic i_write,
  input wire exc_level_t i_level,
  input wire access_ctrl_t i_ctrl,
  output access_result_t o_result
);
  logic sdd_halt;
  assign sdd_halt = i_ctrl.debug_halted && i_ctrl.secure_debug_disable;

  always_comb begin
    o_result = ACC_OK;
    unique case (i_level)
      EL_USER: o_result = ACC_UNDEF;
      EL_KERNEL: begin
        if (i_ctrl.hyp_enabled && i_ctrl.impdef_reg_trap_control) begin
          o_result = ACC_TRAP_HYP;
        end else if (i_write) begin
          if (sdd_halt && i_ctrl.mon_trap_priority &&
              !i_ctrl.mon_cluster_counter_access_enable) begin
            o_result = ACC_UNDEF;
          end else if (i_ctrl.hyp_enabled && !i_ctrl.hyp_cluster_counter_access_enable) begin
            o_result = ACC_TRAP_HYP;
          end else if (!i_ctrl.mon_cluster_counter_access_enable) begin
            o_result = sdd_halt ? ACC_UNDEF : ACC_TRAP_MON;
          end
        end
      end
      EL_HYP: begin
        if (i_write && !i_ctrl.mon_cluster_counter_access_enable) begin
          o_result = sdd_halt ? ACC_UNDEF : ACC_TRAP_MON;
        end
      end
      EL_MONITOR: o_result = ACC_OK;
    endcase
  end
endmodule
`default_nettype wire

// file: irq_gate.sv
// interrupt gate: or of enabled sticky overflow flags
`timescale 1ns/10ps
`default_nettype none
module irq_gate #(
  parameter int N = 6
) (
  input wire logic [N-1:0] i_overflow,
  input wire logic [N-1:0] i_enable,
  output logic o_request
);
  assign o_request = |(i_overflow & i_enable);
endmodule
`default_nettype wire

// file: cluster_counter_irq_enable.sv
// top: set/clear overflow interrupt enables for the cluster event counters
`timescale 1ns/10ps
`default_nettype none
module cluster_counter_irq_enable
  import cluster_counter_irq_pkg::*;
#(
  parameter int N = NUM_COUNTERS
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire cluster_counter_irq_pkg::sysreg_req_t i_req,
  input wire cluster_counter_irq_pkg::access_ctrl_t i_ctrl,
  input wire logic [N-1:0] i_counter_overflow,
  input wire logic [N-1:0] i_overflow_status_clear,
  output cluster_counter_irq_pkg::sysreg_resp_t o_resp,
  output logic [N-1:0] o_overflow_status,
  output logic [N-1:0] o_irq_enable,
  output logic o_irq
);
  import cluster_counter_irq_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic hit_set, hit_clr, hit;
  access_result_t result;
  logic wr_ok;
  logic [N-1:0] enable_q, ovf_q;
  logic irq_d;

  assign hit_set = i_req.valid && (i_req.encoding == ENC_IRQ_ENABLE_SET);
  assign hit_clr = i_req.valid && (i_req.encoding == ENC_IRQ_ENABLE_CLEAR);
  assign hit = hit_set || hit_clr;

  access_checker u_check (
    .i_write(i_req.write),
    .i_level(i_req.level),
    .i_ctrl(i_ctrl),
    .o_result(result)
  );

  assign wr_ok = hit && i_req.write && (result == ACC_OK);

  // ----------------------------------------
  // enable bits
  // ----------------------------------------
  // no reset: software must program them before use
  always_ff @(posedge i_core_clk) begin
    if (wr_ok && hit_set) begin
      enable_q <= enable_q | i_req.wdata[N-1:0];
    end else if (wr_ok && hit_clr) begin
      enable_q <= enable_q & ~i_req.wdata[N-1:0];
    end
  end

  // ----------------------------------------
  // sticky overflow flags
  // ----------------------------------------
  // a new overflow wins over a same-cycle clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ovf_q <= OVF_RESET_VALUE;
    end else begin
      ovf_q <= (ovf_q & ~i_overflow_status_clear) | i_counter_overflow;
    end
  end

  // ----------------------------------------
  // response and outputs
  // ----------------------------------------
  irq_gate #(.N(N)) u_gate (
    .i_overflow(ovf_q),
    .i_enable(enable_q),
    .o_request(irq_d)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_resp <= '0;
    end else begin
      o_resp.valid <= hit;
      o_resp.result <= hit ? result : ACC_OK;
      o_resp.syndrome <= (hit && (result == ACC_TRAP_HYP || result == ACC_TRAP_MON)) ?
                         SYNDROME_SYSREG_TRAP : 6'h00;
      // upper bits always zero
      o_resp.rdata <= (hit && !i_req.write && result == ACC_OK) ?
                      {{(REG_WIDTH-N){1'b0}}, enable_q} : '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
      o_overflow_status <= OVF_RESET_VALUE;
      o_irq_enable <= ENABLE_RESET_VALUE;
    end else begin
      o_irq <= irq_d;
      o_overflow_status <= ovf_q;
      o_irq_enable <= enable_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_USER_UNDEF: assert property (@(posedge i_core_clk) disable iff (i_reset)
    hit && i_req.level == EL_USER |=> o_resp.valid && o_resp.result == ACC_UNDEF)
    else $error("user level access not undefined");
  AST_KERNEL_TRAP: assert property (@(posedge i_core_clk) disable iff (i_reset)
    hit && i_req.level == EL_KERNEL && i_ctrl.hyp_enabled && i_ctrl.impdef_reg_trap_control
    |=> o_resp.result == ACC_TRAP_HYP && o_resp.syndrome == 6'h18)
    else $error("kernel access did not trap to hyp");
  AST_HYP_ACCESS: assert property (@(posedge i_core_clk) disable iff (i_reset)
    hit && i_req.write && i_req.level == EL_KERNEL && i_ctrl.hyp_enabled &&
    !i_ctrl.impdef_reg_trap_control && i_ctrl.mon_cluster_counter_access_enable &&
    !i_ctrl.hyp_cluster_counter_access_enable |=> o_resp.result == ACC_TRAP_HYP)
    else $error("kernel write without hyp access not trapped");
  AST_MON_TRAP: assert property (@(posedge i_core_clk) disable iff (i_reset)
    hit && i_req.write && i_req.level == EL_HYP && !i_ctrl.mon_cluster_counter_access_enable
    |=> o_resp.result == (($past(i_ctrl.debug_halted) && $past(i_ctrl.secure_debug_disable))
        ? ACC_UNDEF : ACC_TRAP_MON))
    else $error("hyp write without monitor access wrong outcome");
  AST_MON_WRITE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    hit_set && i_req.write && i_req.level == EL_MONITOR
    |=> (o_resp.result == ACC_OK) ##1 ((o_irq_enable & $past(i_req.wdata[N-1:0], 2)) ==
        $past(i_req.wdata[N-1:0], 2)))
    else $error("monitor set write did not take effect");
  AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_ok && hit_clr |=> (enable_q & $past(i_req.wdata[N-1:0])) == '0)
    else $error("clear write left an enable set");
  AST_ZERO_KEEP: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_ok && i_req.wdata[N-1:0] == '0 |=> $stable(enable_q))
    else $error("zero write changed enables");
  AST_READ_ZERO: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_resp.valid |-> o_resp.rdata[REG_WIDTH-1:N] == '0)
    else $error("upper read bits not zero");
  AST_IRQ: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ##1 o_irq == $past(|(ovf_q & enable_q)))
    else $error("interrupt does not follow enabled flags");
  AST_STICKY: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_counter_overflow[0] |=> ovf_q[0])
    else $error("overflow flag not set");
endmodule
`default_nettype wire

// file: core_model.sv
// processor core model issuing system register moves to the enable bank
`timescale 1ns/10ps
`default_nettype none
module core_model
  import cluster_counter_irq_pkg::*;
(
  input wire logic i_core_clk,
  input wire cluster_counter_irq_pkg::sysreg_resp_t i_resp,
  output var cluster_counter_irq_pkg::sysreg_req_t o_req
);
  initial o_req = '0;
  // one move per call; the data is scrambled once valid drops so stale data never matches
  task automatic access(input logic wr, input logic [15:0] enc, input logic [63:0] wd,
                        input exc_level_t lvl, output sysreg_resp_t rsp);
    @(posedge i_core_clk);
    o_req <= '{1'b1, wr, enc, wd, lvl};
    @(posedge i_core_clk);
    o_req.valid <= 1'b0;
    o_req.wdata <= ~wd;
    #1 rsp = i_resp;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// testbench: register moves, access checks and interrupt gating
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cluster_counter_irq_pkg::*;
  localparam logic [15:0] SET = ENC_IRQ_ENABLE_SET;
  localparam logic [15:0] CLR = ENC_IRQ_ENABLE_CLEAR;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  sysreg_req_t req;
  access_ctrl_t ctrl = '0;
  logic [5:0] ovf = 6'h00;
  logic [5:0] ovf_clr = 6'h00;
  sysreg_resp_t resp;
  sysreg_resp_t rsp;
  logic [5:0] ovs;
  logic [5:0] en;
  logic irq;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  cluster_counter_irq_enable cluster_counter_irq_enable_i(.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_req(req), .i_ctrl(ctrl), .i_counter_overflow(ovf),
    .i_overflow_status_clear(ovf_clr), .o_resp(resp), .o_overflow_status(ovs),
    .o_irq_enable(en), .o_irq(irq));
  core_model core_model_i(.i_core_clk(i_core_clk), .i_resp(resp), .o_req(req));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] e, input logic [63:0] d);
    core_model_i.access(1'b1, e, d, EL_MONITOR, rsp);
  endtask
  task automatic rd(input logic [15:0] e, input logic [63:0] x);
    core_model_i.access(1'b0, e, 64'h0, EL_MONITOR, rsp);
    check("read valid", 64'(rsp.valid), 64'h1);
    check("rdata", rsp.rdata, x);
  endtask
  task automatic acc(input exc_level_t l, input logic w, input access_ctrl_t c,
                     input access_result_t x);
    @(posedge i_core_clk);
    ctrl <= c;
    core_model_i.access(w, SET, 64'h3E, l, rsp);
    check("result", 64'(rsp.result), 64'(x));
    check("syndrome", 64'(rsp.syndrome), (x > ACC_UNDEF) ? 64'(SYNDROME_SYSREG_TRAP) : 64'h0);
  endtask
  task automatic settle;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask
  // ----------------------------------------
  // hang guard, well above the run length
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_reset <= 1'b0;
    // enables come out of reset undefined, so force a known state first
    wr(CLR, 64'h3F);
    rd(SET, 64'h0);
    wr(SET, 64'hFFFF_FFFF_FFFF_FFC5);
    rd(CLR, 64'h05);
    wr(CLR, 64'hFFFF_FFFF_FFFF_FFC1);
    wr(SET, 64'h0);
    wr(CLR, 64'h0);
    rd(SET, 64'h04);
    check("enable port", 64'(en), 64'h04);
    core_model_i.access(1'b0, 16'hC7AD, 64'h0, EL_MONITOR, rsp);
    check("unmapped valid", 64'(rsp.valid), 64'h0);
    $display("test registers done");
    @(posedge i_core_clk);
    ovf <= 6'h04;
    @(posedge i_core_clk);
    ovf <= 6'h00;
    settle();
    check("status", 64'(ovs), 64'h04);
    check("irq on", 64'(irq), 64'h1);
    wr(CLR, 64'h04);
    settle();
    check("irq masked", 64'(irq), 64'h0);
    check("status kept", 64'(ovs), 64'h04);
    @(posedge i_core_clk);
    ovf_clr <= 6'h04;
    ovf <= 6'h01;
    @(posedge i_core_clk);
    ovf_clr <= 6'h00;
    ovf <= 6'h00;
    settle();
    check("status swap", 64'(ovs), 64'h01);
    check("irq off", 64'(irq), 64'h0);
    wr(SET, 64'h01);
    settle();
    check("irq late", 64'(irq), 64'h1);
    @(posedge i_core_clk);
    ovf_clr <= 6'h01;
    @(posedge i_core_clk);
    ovf_clr <= 6'h00;
    settle();
    check("irq clear", 64'(irq), 64'h0);
    $display("test interrupt done");
    acc(EL_USER, 1'b0, 7'b0011000, ACC_UNDEF);
    acc(EL_KERNEL, 1'b0, 7'b1111000, ACC_TRAP_HYP);
    acc(EL_KERNEL, 1'b1, 7'b1001000, ACC_TRAP_HYP);
    acc(EL_KERNEL, 1'b1, 7'b0010000, ACC_TRAP_MON);
    acc(EL_HYP, 1'b1, 7'b0010110, ACC_UNDEF);
    acc(EL_KERNEL, 1'b1, 7'b1000111, ACC_UNDEF);
    acc(EL_KERNEL, 1'b1, 7'b1000110, ACC_TRAP_HYP);
    acc(EL_HYP, 1'b0, 7'b0000000, ACC_OK);
    rd(SET, 64'h01);
    acc(EL_MONITOR, 1'b1, 7'b0000000, ACC_OK);
    rd(CLR, 64'h3F);
    $display("test access done");
    end_of_test();
  end
endmodule
`default_nettype wire
